// ==== design/assc_pkg.sv ====
// constants, field positions and types of the serial channel
// Functional notes
// - async mode transmits and receives at once, up to 625 KBaud.
// - sync mode is half duplex, transmit or receive, up to 2.5 Mbaud.
// - own programmable baud generator sets any standard rate.
// - separate transmit, receive and error interrupt requests.
// - async frame is start bit, 8 or 9 data bits, one or two stops.
// - wake-up mode adds ninth bit marking address characters.
// - sync mode moves bytes against a shift clock made here.
// - least significant bit is always shifted first.
// - loopback routes transmitted data back to the receiver.
// - parity generated on transmit, checked on receive, error flagged.
// - missing stop bit flags a framing error when enabled.
// - unread buffer at next completed reception flags overrun when enabled.
package assc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ASYNC_MAX_BAUD = 625_000;
  localparam int unsigned SYNC_MAX_BAUD = 2_500_000;
  localparam int unsigned OVS = 16;
  // smallest useful divisor, in clock cycles per tick
  localparam int unsigned ASYNC_MIN_DIV = CLK_HZ / (OVS * ASYNC_MAX_BAUD);
  localparam int unsigned SYNC_MIN_DIV = CLK_HZ / (2 * SYNC_MAX_BAUD);
  // word addresses
  localparam logic [2:0] ADR_CTRL = 3'h0;
  localparam logic [2:0] ADR_BAUD = 3'h1;
  localparam logic [2:0] ADR_TXD = 3'h2;
  localparam logic [2:0] ADR_RXD = 3'h3;
  localparam logic [2:0] ADR_STAT = 3'h4;
  localparam logic [2:0] ADR_MASK = 3'h5;
  localparam logic [2:0] ADR_STATE = 3'h6;
  // control fields
  localparam int CB_STOP2 = 2;
  localparam int CB_PAR = 3;
  localparam int CB_ODD = 4;
  localparam int CB_FEN = 5;
  localparam int CB_OEN = 6;
  localparam int CB_LOOP = 7;
  localparam int CB_REN = 8;
  localparam int CB_ADDR = 9;
  // status fields
  localparam int ST_TX = 0;
  localparam int ST_RX = 1;
  localparam int ST_PE = 2;
  localparam int ST_FE = 3;
  localparam int ST_OE = 4;
  // reset values, then oversampling mid and last counts
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [15:0] BAUD_RST = 16'h0035;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  typedef enum logic [1:0] {
    M_ASYNC8 = 2'h0,
    M_ASYNC9 = 2'h1,
    M_WAKE = 2'h2,
    M_SYNC = 2'h3
  } assc_mode_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } assc_tx_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS = 4'b0100,
    RX_DONE = 4'b1000
  } assc_rx_t;
endpackage : assc_pkg

// ==== design/assc_top.sv ====
// serial channel: avalon slave, baud generator, async/sync transmitter and receiver
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module assc_top #(
  parameter int BAUD_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // avalon-mm slave
  input wire logic [2:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // serial pins
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_rxd_o,
  output logic o_rxd_oe,
  // interrupts
  output logic o_irq,
  output logic o_tx_irq,
  output logic o_rx_irq,
  output logic o_err_irq
);
  // bus, registers and baud generator
  logic wait_q, req, wr_acc, rd_acc;
  logic [31:0] rdata_q, rd_mux;
  logic [9:0] ctrl_q;
  logic [BAUD_W-1:0] baud_q, bg_cnt_q;
  logic [4:0] mask_q, stat_q;
  logic tick_q, sync_m, nine, par_en, sclk_q;
  assc_pkg::assc_mode_t mode;
  logic s1_q, s2_q, s3_q, rxf_q, rx_in;
  // transmitter
  assc_pkg::assc_tx_t tx_st_q;
  logic [12:0] tx_sr_q, tx_frame;
  logic [3:0] tx_len, tx_left_q, tx_os_q;
  logic txd_q, tx_done_q, tx_start;
  logic [8:0] wd;
  // receiver
  assc_pkg::assc_rx_t rx_st_q;
  logic [11:0] rx_sr_q;
  logic [3:0] rx_idx_q, rx_os_q, rx_last;
  logic [8:0] rx_data, rxbuf_q;
  logic rx_parbit, rx_stop, rx_drop, rx_full_q, rx_done_q;
  logic pe_q, fe_q, oe_q, ren_clr_q, rx_busy, rx_prev_q;

  assign req = i_read | i_write;
  assign wr_acc = i_write & ~wait_q;
  assign rd_acc = i_read & ~wait_q;
  assign mode = assc_pkg::assc_mode_t'(ctrl_q[1:0]);
  assign sync_m = (mode == assc_pkg::M_SYNC);
  assign nine = (mode == assc_pkg::M_ASYNC9) || (mode == assc_pkg::M_WAKE);
  assign par_en = ctrl_q[assc_pkg::CB_PAR] & ~sync_m;
  assign rx_busy = (rx_st_q != assc_pkg::RX_IDLE);
  assign wd = i_writedata[8:0];
  // sync mode is half duplex: no transmit while receiving
  assign tx_start = wr_acc && (i_address == assc_pkg::ADR_TXD) && (tx_st_q == assc_pkg::TX_IDLE)
                    && !(sync_m && rx_busy);

  // one wait cycle, then the access completes
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_address)
      assc_pkg::ADR_CTRL: rd_mux[9:0] = ctrl_q;
      assc_pkg::ADR_BAUD: rd_mux[BAUD_W-1:0] = baud_q;
      assc_pkg::ADR_RXD: rd_mux[8:0] = rxbuf_q;
      assc_pkg::ADR_STAT: rd_mux[4:0] = stat_q;
      assc_pkg::ADR_MASK: rd_mux[4:0] = mask_q;
      assc_pkg::ADR_STATE: rd_mux[2:0] = {rx_full_q, rx_busy, tx_st_q == assc_pkg::TX_BUSY};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_read & wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_q <= assc_pkg::CTRL_RST;
      baud_q <= BAUD_W'(assc_pkg::BAUD_RST);
      mask_q <= assc_pkg::MASK_RST;
    end else if (wr_acc) begin
      if (i_address == assc_pkg::ADR_CTRL) ctrl_q <= i_writedata[9:0];
      if (i_address == assc_pkg::ADR_BAUD) baud_q <= i_writedata[BAUD_W-1:0];
      if (i_address == assc_pkg::ADR_MASK) mask_q <= i_writedata[4:0];
    end else if (ren_clr_q) begin
      ctrl_q[assc_pkg::CB_REN] <= 1'b0;
    end
  end

  // reloadable down counter; tick on reaching zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bg_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (bg_cnt_q == '0);
      bg_cnt_q <= (bg_cnt_q == '0) ? baud_q : bg_cnt_q - 1'b1;
    end
  end

  // status: hardware set wins over a write-one clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stat_q <= 5'h00;
    end else begin
      stat_q <= (stat_q & ~((wr_acc && i_address == assc_pkg::ADR_STAT) ? i_writedata[4:0] : 5'h00))
                | {oe_q, fe_q, pe_q, rx_done_q, tx_done_q};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_tx_irq <= 1'b0;
      o_rx_irq <= 1'b0;
      o_err_irq <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_tx_irq <= stat_q[assc_pkg::ST_TX] & mask_q[assc_pkg::ST_TX];
      o_rx_irq <= stat_q[assc_pkg::ST_RX] & mask_q[assc_pkg::ST_RX];
      o_err_irq <= |(stat_q[4:2] & mask_q[4:2]);
      o_irq <= |(stat_q & mask_q);
    end
  end

  // pin synchroniser: a level counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      rxf_q <= 1'b1;
    end else begin
      s1_q <= i_rxd;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) rxf_q <= s3_q;
    end
  end

  assign rx_in = ctrl_q[assc_pkg::CB_LOOP] ? txd_q : rxf_q;

  // shift clock idles high; data moves on falling edges, sampled on rising
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sclk_q <= 1'b1;
    end else if (sync_m && tick_q && (tx_st_q == assc_pkg::TX_BUSY || rx_st_q == assc_pkg::RX_BITS)) begin
      sclk_q <= ~sclk_q;
    end else if (!sync_m) begin
      sclk_q <= 1'b1;
    end
  end

  always_comb begin
    tx_frame = 13'h1fff;
    if (sync_m) begin
      tx_frame[7:0] = wd[7:0];
      tx_len = 4'd8;
    end else begin
      tx_frame[0] = 1'b0;
      tx_frame[8:1] = wd[7:0];
      if (nine) tx_frame[9] = wd[8];
      if (par_en) tx_frame[nine ? 10 : 9] = ^(nine ? wd : {1'b0, wd[7:0]}) ^ ctrl_q[assc_pkg::CB_ODD];
      tx_len = 4'd10 + {3'b000, nine} + {3'b000, par_en} + {3'b000, ctrl_q[assc_pkg::CB_STOP2]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tx_st_q <= assc_pkg::TX_IDLE;
      tx_sr_q <= 13'h1fff;
      tx_left_q <= 4'h0;
      tx_os_q <= 4'h0;
      txd_q <= 1'b1;
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      case (tx_st_q)
        assc_pkg::TX_IDLE: begin
          txd_q <= 1'b1;
          if (tx_start) begin
            tx_st_q <= assc_pkg::TX_BUSY;
            tx_sr_q <= tx_frame;
            tx_left_q <= tx_len;
            tx_os_q <= 4'h0;
            txd_q <= tx_frame[0];
          end
        end
        assc_pkg::TX_BUSY: begin
          if (tick_q && !sync_m) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == assc_pkg::OS_LAST) begin
              if (tx_left_q == 4'h1) begin
                tx_st_q <= assc_pkg::TX_IDLE;
                txd_q <= 1'b1;
                tx_done_q <= 1'b1;
              end else begin
                tx_sr_q <= {1'b1, tx_sr_q[12:1]};
                txd_q <= tx_sr_q[1];
                tx_left_q <= tx_left_q - 4'h1;
              end
            end
          end else if (tick_q) begin
            if (!sclk_q) begin
              tx_os_q[0] <= 1'b1;
              tx_left_q <= tx_left_q - 4'h1;
              if (tx_left_q == 4'h1) begin
                tx_st_q <= assc_pkg::TX_IDLE;
                tx_done_q <= 1'b1;
              end
            end else if (tx_os_q[0]) begin
              tx_sr_q <= {1'b1, tx_sr_q[12:1]};
              txd_q <= tx_sr_q[1];
            end
          end
        end
        default: tx_st_q <= assc_pkg::TX_IDLE;
      endcase
    end
  end

  // receive frame decode
  assign rx_last = sync_m ? 4'd7 : 4'd8 + {3'b000, nine} + {3'b000, par_en};
  assign rx_data = (nine && !sync_m) ? rx_sr_q[8:0] : {1'b0, rx_sr_q[7:0]};
  assign rx_parbit = nine ? rx_sr_q[9] : rx_sr_q[8];
  assign rx_stop = rx_sr_q[rx_last];
  assign rx_drop = (mode == assc_pkg::M_WAKE) && ctrl_q[assc_pkg::CB_ADDR] && !rx_data[8];

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_st_q <= assc_pkg::RX_IDLE;
      rx_sr_q <= 12'h000;
      rx_idx_q <= 4'h0;
      rx_os_q <= 4'h0;
      rxbuf_q <= 9'h000;
      rx_done_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
      ren_clr_q <= 1'b0;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_in;
      rx_done_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
      ren_clr_q <= 1'b0;
      case (rx_st_q)
        assc_pkg::RX_IDLE: begin
          rx_os_q <= 4'h0;
          rx_idx_q <= 4'h0;
          // start is a falling edge, so a low stop bit cannot restart the receiver
          if (ctrl_q[assc_pkg::CB_REN] && !sync_m && !rx_in && rx_prev_q) rx_st_q <= assc_pkg::RX_START;
          // enable clear lands one cycle late; no second byte meanwhile
          if (ctrl_q[assc_pkg::CB_REN] && sync_m && tx_st_q == assc_pkg::TX_IDLE && !tx_start && !ren_clr_q) begin
            rx_st_q <= assc_pkg::RX_BITS;
          end
        end
        assc_pkg::RX_START: begin
          if (tick_q) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == assc_pkg::OS_MID) begin
              rx_os_q <= 4'h0;
              rx_st_q <= rx_in ? assc_pkg::RX_IDLE : assc_pkg::RX_BITS; // glitch rejected
            end
          end
        end
        assc_pkg::RX_BITS: begin
          if (tick_q && (sync_m ? !sclk_q : rx_os_q == assc_pkg::OS_LAST)) begin
            rx_sr_q[rx_idx_q] <= rx_in;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == rx_last) rx_st_q <= assc_pkg::RX_DONE;
          end
          if (tick_q) rx_os_q <= rx_os_q + 4'h1;
        end
        assc_pkg::RX_DONE: begin
          rx_st_q <= assc_pkg::RX_IDLE;
          ren_clr_q <= sync_m;
          if (!rx_drop) begin
            rxbuf_q <= rx_data;
            rx_done_q <= 1'b1;
            pe_q <= par_en && (rx_parbit != (^rx_data ^ ctrl_q[assc_pkg::CB_ODD]));
            fe_q <= !sync_m && ctrl_q[assc_pkg::CB_FEN] && !rx_stop;
            oe_q <= ctrl_q[assc_pkg::CB_OEN] && rx_full_q && !(rd_acc && i_address == assc_pkg::ADR_RXD);
          end
        end
        default: rx_st_q <= assc_pkg::RX_IDLE;
      endcase
    end
  end

  // buffer full: new character wins over a simultaneous read
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_full_q <= 1'b0;
    end else if (rx_done_q) begin
      rx_full_q <= 1'b1;
    end else if (rd_acc && i_address == assc_pkg::ADR_RXD) begin
      rx_full_q <= 1'b0;
    end
  end

  // pins stay quiet in loopback
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_txd <= 1'b1;
      o_rxd_o <= 1'b1;
      o_rxd_oe <= 1'b0;
    end else begin
      o_txd <= ctrl_q[assc_pkg::CB_LOOP] | (sync_m ? sclk_q : txd_q);
      o_rxd_o <= txd_q;
      // enable held past the last rising shift clock so the far side still sees the data
      o_rxd_oe <= sync_m && (tx_st_q == assc_pkg::TX_BUSY || tx_done_q) && !ctrl_q[assc_pkg::CB_LOOP];
    end
  end

  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
endmodule : assc_top

// ==== tb/assc_peer.sv ====
// far-side serial model: async frames and sync bytes, lsb first
`timescale 1ns/1ps
module assc_peer #(
  parameter int BIT_CLKS = 160
) (
  // clock
  input wire logic i_clk,
  // device tx line or sync shift clock, and sync data wire
  input wire logic i_line,
  input wire logic i_data,
  // line into the device
  output logic o_line
);
  // mark level, as on a pulled-up idle line
  initial o_line = 1'b1;
  // start bit, then n bits lsb first, then back to idle
  task automatic send(input logic [10:0] bits, input int n);
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_line <= bits[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask : send
  // samples mid bit after the start edge
  task automatic recv(output logic [10:0] bits, input int n);
    bits = '0;
    @(negedge i_line);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      bits[i] = i_line;
    end
  endtask : recv
  // data changes after the falling shift clock, taken at the rising one
  task automatic sync(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      @(negedge i_line);
      o_line <= tx[i];
      @(posedge i_line);
      rx[i] = i_data;
    end
    o_line <= 1'b1;
  endtask : sync
endmodule : assc_peer

// ==== tb/assc_assertions.sv ====
// checker: bus handshake, reset state, interrupts, loopback and shift clock
`timescale 1ns/1ps
module assc_chk #(
  parameter int BAUD_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // bus
  input wire logic [2:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // pins and interrupts
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_rxd_o,
  input wire logic o_rxd_oe,
  input wire logic o_irq,
  input wire logic o_tx_irq,
  input wire logic o_rx_irq,
  input wire logic o_err_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [9:0] ctrl_q;
  logic [4:0] mask_q;
  logic [BAUD_W-1:0] baud_q;
  logic [BAUD_W:0] cnt_q;
  // mirrors of written registers; hardware clearing of receive enable is not tracked
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_q <= assc_pkg::CTRL_RST;
      mask_q <= assc_pkg::MASK_RST;
      baud_q <= BAUD_W'(assc_pkg::BAUD_RST);
    end else if (i_write && !o_waitrequest) begin
      if (i_address == assc_pkg::ADR_CTRL) ctrl_q <= i_writedata[9:0];
      if (i_address == assc_pkg::ADR_MASK) mask_q <= i_writedata[4:0];
      if (i_address == assc_pkg::ADR_BAUD) baud_q <= i_writedata[BAUD_W-1:0];
    end
  end
  // cycles since the shift clock pin last moved
  always_ff @(posedge i_clk) begin
    if (!i_resetn || $changed(o_txd)) cnt_q <= (BAUD_W+1)'(1);
    else cnt_q <= cnt_q + 1'b1;
  end
  AST_WAIT_ONE: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RESET_IDLE: assert property ($rose(i_resetn) |-> o_waitrequest && o_txd && !o_rxd_oe && !o_irq)
    else $error("outputs not idle after reset");
  AST_UNMAPPED: assert property (i_read && i_address == 3'h7 && !o_waitrequest |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_ANY: assert property (o_irq == (o_tx_irq || o_rx_irq || o_err_irq))
    else $error("summary irq disagrees with sources");
  AST_TX_MASKED: assert property (!mask_q[0] && !$past(mask_q[0]) |-> !o_tx_irq)
    else $error("masked transmit irq raised");
  AST_ERR_MASKED: assert property (mask_q[4:2] == 3'h0 && $past(mask_q[4:2]) == 3'h0 |-> !o_err_irq)
    else $error("masked error irq raised");
  AST_LOOP_IDLE: assert property (ctrl_q[7] && $past(ctrl_q[7]) && ctrl_q[1:0] != 2'h3 |-> o_txd)
    else $error("tx pin moved in loopback");
  AST_SCLK_HALF: assert property (o_rxd_oe && $rose(o_txd) |-> cnt_q == {1'b0, baud_q} + 1'b1)
    else $error("shift clock half period wrong");
  AST_DATA_STABLE: assert property (o_rxd_oe && $rose(o_txd) |-> $stable(o_rxd_o))
    else $error("sync data moved at rising shift clock");
  COV_SYNC: cover property (o_rxd_oe && $rose(o_txd));
  COV_ERR: cover property ($rose(o_err_irq));
  COV_RX: cover property ($rose(o_rx_irq));
endmodule : assc_chk

bind assc_top assc_chk #(.BAUD_W(BAUD_W)) i_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_rxd(i_rxd), .o_txd(o_txd), .o_rxd_o(o_rxd_o), .o_rxd_oe(o_rxd_oe),
  .o_irq(o_irq), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_err_irq(o_err_irq)
);

// ==== tb/tb_top.sv ====
// testbench: registers, async duplex, errors, wake-up, loopback, sync
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [2:0] i_address = 3'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_txd, o_rxd_o, o_rxd_oe, o_irq, o_tx_irq, o_rx_irq, o_err_irq;
  logic peer_line, i_rxd;
  logic [2:0] irqs;
  logic [31:0] d;
  logic [10:0] fb;
  logic [7:0] sb;
  int n_fail = 0;
  int cmp_count = 0;
  // shared data pin: device drives only while its enable is up
  assign i_rxd = o_rxd_oe ? o_rxd_o : peer_line;
  assign irqs = {o_err_irq, o_rx_irq, o_tx_irq};
  always #5 i_clk = ~i_clk;
  assc_top #(.BAUD_W(16)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_rxd(i_rxd), .o_txd(o_txd), .o_rxd_o(o_rxd_o), .o_rxd_oe(o_rxd_oe),
    .o_irq(o_irq), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_err_irq(o_err_irq)
  );
  // baud reload 9: 160 clocks a bit
  assc_peer #(.BIT_CLKS(160)) i_peer (.i_clk(i_clk), .i_line(o_txd), .i_data(i_rxd), .o_line(peer_line));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    i_address <= a;
    i_writedata <= v;
    i_write <= 1'b1;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [31:0] v);
    i_address <= a;
    i_read <= 1'b1;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    v = o_readdata;
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask : rd
  task automatic wirq(input int k);
    for (int n = 0; n < 3000 && irqs[k] !== 1'b1; n++) @(posedge i_clk);
  endtask : wirq
  task automatic t_regs();
    rd(3'h0, d); chk(d, 32'(assc_pkg::CTRL_RST));
    rd(3'h1, d); chk(d, 32'(assc_pkg::BAUD_RST));
    rd(3'h5, d); chk(d, 32'(assc_pkg::MASK_RST));
    wr(3'h7, 32'hffff);
    rd(3'h7, d); chk(d, 32'h0);
    wr(3'h1, 32'h9);
    rd(3'h1, d); chk(d, 32'h9);
    $display("test regs done");
  endtask : t_regs
  task automatic t_duplex();
    wr(3'h5, 32'h1);
    wr(3'h0, 32'h100);
    fork
      i_peer.recv(fb, 9);
      i_peer.send(11'h13c, 9);
      wr(3'h2, 32'ha5);
    join
    chk(fb, 11'h1a5);
    wirq(0);
    rd(3'h4, d); chk(d, 32'h3);
    chk(irqs, 3'h1);
    rd(3'h3, d); chk(d, 32'h3c);
    wr(3'h4, 32'h3);
    rd(3'h4, d); chk(d, 32'h0);
    chk(o_irq, 1'b0);
    wr(3'h5, 32'h1f);
    $display("test duplex done");
  endtask : t_duplex
  task automatic t_nine();
    wr(3'h0, 32'h119);
    fork
      i_peer.recv(fb, 11);
      i_peer.send(11'h5a5, 11);
      wr(3'h2, 32'h1c3);
    join
    chk(fb, 11'h5c3);
    wirq(1);
    wirq(0);
    rd(3'h4, d); chk(d, 32'h3);
    rd(3'h3, d); chk(d, 32'h1a5);
    wr(3'h4, 32'h1f);
    $display("test nine done");
  endtask : t_nine
  task automatic t_errors();
    wr(3'h0, 32'h168);
    fork
      i_peer.recv(fb, 10);
      i_peer.send(11'h201, 10);
      wr(3'h2, 32'h07);
    join
    chk(fb, 11'h307);
    wirq(2);
    rd(3'h4, d); chk(d[4:1], 4'h3);
    chk(o_err_irq, 1'b1);
    rd(3'h3, d);
    wr(3'h4, 32'h1f);
    i_peer.send(11'h000, 10);
    wirq(2);
    rd(3'h4, d); chk(d, 32'ha);
    i_peer.send(11'h255, 10);
    wirq(1);
    rd(3'h4, d); chk(d, 32'h1a);
    rd(3'h3, d); chk(d, 32'h55);
    wr(3'h4, 32'h1f);
    rd(3'h4, d); chk(o_err_irq, 1'b0);
    $display("test errors done");
  endtask : t_errors
  task automatic t_wake();
    wr(3'h0, 32'h306);
    i_peer.send(11'h211, 10);
    rd(3'h4, d); chk(d, 32'h0);
    fork
      i_peer.recv(fb, 11);
      i_peer.send(11'h322, 10);
      wr(3'h2, 32'h1a5);
    join
    chk(fb, 11'h7a5);
    wirq(1);
    wirq(0);
    rd(3'h3, d); chk(d, 32'h122);
    wr(3'h4, 32'h1f);
    $display("test wake done");
  endtask : t_wake
  task automatic t_loop();
    wr(3'h0, 32'h180);
    wr(3'h2, 32'h5a);
    wirq(1);
    // transmitter must be idle before the next mode change
    wirq(0);
    rd(3'h3, d); chk(d, 32'h5a);
    wr(3'h4, 32'h1f);
    $display("test loop done");
  endtask : t_loop
  task automatic t_sync();
    wr(3'h0, 32'h3);
    fork
      i_peer.sync(8'h00, sb);
      wr(3'h2, 32'hc3);
    join
    chk(sb, 8'hc3);
    wirq(0);
    wr(3'h4, 32'h1f);
    fork
      i_peer.sync(8'h96, sb);
      wr(3'h0, 32'h103);
    join
    wirq(1);
    rd(3'h3, d); chk(d, 32'h96);
    rd(3'h0, d); chk(d, 32'h3);
    $display("test sync done");
  endtask : t_sync
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ten frames of about two thousand clocks each fit well inside this span
  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_duplex();
    t_nine();
    t_errors();
    t_wake();
    t_loop();
    t_sync();
    results();
  end
endmodule : tb_top
